// *** cfg_hdr_pkg.sv ***
/*
  Constants and carrier types for the host-bridge configuration header
  status block. Assumes byte-addressed configuration cycles with per-byte
  enables on a 32-bit dword, as a configuration space access delivers them.
*/
package cfg_hdr_pkg;

  // Byte offsets in configuration space
  localparam logic [7:0] status_offset         = 8'h06;
  localparam logic [7:0] revision_offset       = 8'h08;
  localparam logic [7:0] subclass_offset       = 8'h0a;
  localparam logic [7:0] base_class_offset     = 8'h0b;
  localparam logic [7:0] latency_offset        = 8'h0d;
  localparam logic [7:0] header_offset         = 8'h0e;
  localparam logic [7:0] cap_pointer_offset    = 8'h34;

  // Status field positions
  localparam int parity_error_seen_pos  = 15;
  localparam int system_error_sent_pos  = 14;
  localparam int got_master_abort_pos   = 13;
  localparam int got_target_abort_pos   = 12;

  // Fixed values
  localparam logic [15:0] status_reset      = 16'h0090;
  localparam logic [1:0]  select_decode_fast = 2'h0;
  localparam logic [7:0]  bridge_subclass   = 8'h00;
  localparam logic [7:0]  base_class        = 8'h06;
  localparam logic [7:0]  latency_timer     = 8'h00;
  localparam logic [7:0]  header_layout     = 8'h00;
  // Arbitrary neutral revision value
  localparam logic [7:0]  revision_default  = 8'h01;

  // Configuration access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [5:0]  dword;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } cfg_req_t;

  // Hub-link error events, one-cycle pulses
  typedef struct packed {
    logic serr_cond;
    logic master_abort;
    logic target_abort;
  } hub_events_t;

endpackage : cfg_hdr_pkg

// *** hb_status_properties.sv ***
/* Port checker for the status header block.
   Bound to the top module; sees its ports only. */
module hb_status_properties #(
  parameter logic [7:0] cap_pointer = 8'h00
) (
  // Clock and reset
  input wire logic                     sys_clk_i,
  input wire logic                     rst_i,
  // Watched ports
  input wire cfg_hdr_pkg::cfg_req_t    cfg_req_i,
  input wire logic [31:0]              cfg_rdata_o,
  input wire logic                     cfg_rvalid_o,
  input wire logic                     system_error_enable_i,
  input wire cfg_hdr_pkg::hub_events_t hub_events_i,
  input wire logic                     serr_message_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic st;
  logic sc;
  assign st = cfg_req_i.rd && cfg_req_i.dword == 6'h01;
  assign sc = hub_events_i.serr_cond;
  property p_msg;
    sc && system_error_enable_i |=> serr_message_o;
  endproperty
  a_msg: assert property (p_msg) else $error("no serr msg");
  property p_gate;
    serr_message_o |-> $past(sc && system_error_enable_i);
  endproperty
  a_gate: assert property (p_gate) else $error("serr gate");
  property p_hw;
    cfg_rvalid_o && $past(st) |-> !cfg_rdata_o[31]
      && cfg_rdata_o[27:16] == 12'h090;
  endproperty
  a_hw: assert property (p_hw) else $error("status");
  property p_cls;
    cfg_rvalid_o && $past(cfg_req_i.dword) == 6'h02
      |-> cfg_rdata_o[31:16] == 16'h0600;
  endproperty
  a_cls: assert property (p_cls) else $error("class");
  property p_dw3;
    cfg_rvalid_o && $past(cfg_req_i.dword) == 6'h03
      |-> cfg_rdata_o[23:8] == 16'h0000;
  endproperty
  a_dw3: assert property (p_dw3) else $error("dw3");
  property p_cap;
    cfg_rvalid_o && $past(cfg_req_i.dword) == 6'h0d
      |-> cfg_rdata_o[7:0] == cap_pointer;
  endproperty
  a_cap: assert property (p_cap) else $error("cap ptr");
  property p_set;
    serr_message_o && !cfg_req_i.wr ##1 st |=> cfg_rdata_o[30];
  endproperty
  a_set: assert property (p_set) else $error("sse set");
  // A write in between could clear the flag before the read
  property p_rma;
    hub_events_i.master_abort ##1 !cfg_req_i.wr ##1 st |=> cfg_rdata_o[29];
  endproperty
  a_rma: assert property (p_rma) else $error("rma set");
  // Serr quiet throughout, since a set would win over the clear
  property p_clr;
    cfg_req_i.wr && cfg_req_i.dword == 6'h01 && cfg_req_i.byte_en[3]
      && cfg_req_i.wdata[30] && !sc ##1 !sc ##1 st && !sc
      |=> !cfg_rdata_o[30];
  endproperty
  a_clr: assert property (p_clr) else $error("sse clear");
endmodule : hb_status_properties

bind host_bridge_config_header_status hb_status_properties #(
  .cap_pointer(cap_pointer)
) hb_status_properties_inst (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cfg_req_i(cfg_req_i),
  .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
  .system_error_enable_i(system_error_enable_i),
  .hub_events_i(hub_events_i), .serr_message_o(serr_message_o));

// *** host_bridge_config_header_status.sv ***
/*
  Status, revision, class, latency and header-type bytes of the host-bridge
  configuration header. Assumes the configuration decoder presents one
  dword access per cycle for this function and takes read data the cycle
  after the request. Command-register enable arrives as a level.
*/
module host_bridge_config_header_status #(
  parameter logic [7:0] revision_number = cfg_hdr_pkg::revision_default,
  parameter logic [7:0] cap_pointer     = 8'h00
) (
  // Clock and reset
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_i,
  // Configuration access
  input  wire cfg_hdr_pkg::cfg_req_t    cfg_req_i,
  output logic [31:0]                   cfg_rdata_o,
  output logic                          cfg_rvalid_o,
  // Command register enable and hub events
  input  wire logic                     system_error_enable_i,
  input  wire cfg_hdr_pkg::hub_events_t hub_events_i,
  // SERR message request to the hub link
  output logic                          serr_message_o
);

  typedef struct packed {
    logic [31:0] rdata;
    logic        rvalid;
    logic        serr_msg;
  } bank_state_t;

  bank_state_t state;
  bank_state_t next_state;

  logic        system_error_sent_flag;
  logic        got_master_abort_flag;
  logic        got_target_abort_flag;
  logic        status_write;
  logic        clear_sse;
  logic        clear_rma;
  logic        clear_rta;
  logic        send_serr;
  logic [15:0] function_status;

  // Only the upper status byte holds writable flags
  assign status_write = cfg_req_i.wr
                        && (cfg_req_i.dword == cfg_hdr_pkg::status_offset[7:2])
                        && cfg_req_i.byte_en[3];
  // A written 0 clears nothing
  assign clear_sse = status_write
    && cfg_req_i.wdata[16 + cfg_hdr_pkg::system_error_sent_pos];
  assign clear_rma = status_write
    && cfg_req_i.wdata[16 + cfg_hdr_pkg::got_master_abort_pos];
  assign clear_rta = status_write
    && cfg_req_i.wdata[16 + cfg_hdr_pkg::got_target_abort_pos];

  // Message leaves only with the enable set
  assign send_serr = hub_events_i.serr_cond && system_error_enable_i;

  w1c_flag sse_flag (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .set_i     (send_serr),
    .clear_i   (clear_sse),
    .flag_o    (system_error_sent_flag)
  );

  w1c_flag rma_flag (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .set_i     (hub_events_i.master_abort),
    .clear_i   (clear_rma),
    .flag_o    (got_master_abort_flag)
  );

  w1c_flag rta_flag (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .set_i     (hub_events_i.target_abort),
    .clear_i   (clear_rta),
    .flag_o    (got_target_abort_flag)
  );

  // Flags clear at reset, giving 0090h
  always_comb begin
    function_status     = '0;
    function_status[15] = 1'b0;
    function_status[14] = system_error_sent_flag;
    function_status[13] = got_master_abort_flag;
    function_status[12] = got_target_abort_flag;
    function_status[11] = 1'b0;
    function_status[10:9] = cfg_hdr_pkg::select_decode_fast;
    function_status[8]  = 1'b0;
    function_status[7]  = 1'b1;
    function_status[4]  = 1'b1;
  end

  always_comb begin
    next_state          = state;
    next_state.rvalid   = cfg_req_i.rd;
    next_state.serr_msg = send_serr;
    if (cfg_req_i.rd) begin
      next_state.rdata = '0;
      // Read-only bytes are constants, so writes simply fall away
      case (cfg_req_i.dword)
        cfg_hdr_pkg::status_offset[7:2]: begin
          next_state.rdata[31:16] = function_status;
        end
        cfg_hdr_pkg::revision_offset[7:2]: begin
          next_state.rdata[7:0]   = revision_number;
          next_state.rdata[23:16] = cfg_hdr_pkg::bridge_subclass;
          next_state.rdata[31:24] = cfg_hdr_pkg::base_class;
        end
        cfg_hdr_pkg::latency_offset[7:2]: begin
          next_state.rdata[15:8]  = cfg_hdr_pkg::latency_timer;
          next_state.rdata[23:16] = cfg_hdr_pkg::header_layout;
        end
        cfg_hdr_pkg::cap_pointer_offset[7:2]: begin
          next_state.rdata[7:0]   = cap_pointer;
        end
        default: begin
          next_state.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign cfg_rdata_o    = state.rdata;
  assign cfg_rvalid_o   = state.rvalid;
  assign serr_message_o = state.serr_msg;

endmodule : host_bridge_config_header_status

// *** host_bridge_config_header_status_tb.sv ***
/* Bench for the status header block, stimulus on the falling edge.
   Assumes the checker binds itself to the design. */
module host_bridge_config_header_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  logic                     en = 1'b0;
  cfg_hdr_pkg::cfg_req_t    req = '0;
  cfg_hdr_pkg::hub_events_t hev = '0;
  logic [31:0]              rdata;
  logic                     rvalid;
  logic                     msg;
  int                       mismatches = 0;
  int                       compares = 0;
  always #5 clk = ~clk;
  host_bridge_config_header_status #(.revision_number(8'h5a),
    .cap_pointer(8'ha4)) host_bridge_config_header_status_inst (
    .sys_clk_i(clk), .rst_i(rst), .cfg_req_i(req), .cfg_rdata_o(rdata),
    .cfg_rvalid_o(rvalid), .system_error_enable_i(en),
    .hub_events_i(hev), .serr_message_o(msg));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Mask hides bytes that belong to other registers
  task automatic rd(logic [5:0] d, logic [31:0] m, logic [31:0] e);
    @(negedge clk);
    req = {1'b1, 1'b0, d, 4'h0, 32'h0};
    @(negedge clk);
    req = '0;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    chk("rdata", e, rdata & m);
  endtask : rd
  task automatic wr(logic [5:0] d, logic [3:0] b, logic [31:0] w);
    @(negedge clk);
    req = {1'b0, 1'b1, d, b, w};
    @(negedge clk);
    req = '0;
  endtask : wr
  task automatic pulse(logic [2:0] v, logic e, logic m);
    @(negedge clk);
    en = e;
    hev = v;
    @(negedge clk);
    hev = '0;
    chk("serr_message", {31'h0, m}, {31'h0, msg});
  endtask : pulse
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    // Second pass follows all-ones writes to read-only bytes
    for (int p = 0; p < 2; p++) begin
      rd(6'h01, 32'hffff_0000, 32'h0090_0000);
      rd(6'h02, 32'hffff_00ff, 32'h0600_005a);
      rd(6'h03, 32'h00ff_ff00, 32'h0);
      rd(6'h0d, 32'h0000_00ff, 32'h0000_00a4);
      rd(6'h3f, 32'hffff_ffff, 32'h0);
      for (int d = 1; d < 4; d++) wr(6'(d), 4'hf, '1);
    end
    pulse(3'b100, 1'b0, 1'b0);
    rd(6'h01, 32'hffff_0000, 32'h0090_0000);
    pulse(3'b010, 1'b1, 1'b0);
    pulse(3'b001, 1'b1, 1'b0);
    pulse(3'b100, 1'b1, 1'b1);
    rd(6'h01, 32'hffff_0000, 32'h7090_0000);
    wr(6'h01, 4'h8, 32'h0);
    wr(6'h01, 4'h7, '1);
    rd(6'h01, 32'hffff_0000, 32'h7090_0000);
    wr(6'h01, 4'h8, 32'h2000_0000);
    rd(6'h01, 32'hffff_0000, 32'h5090_0000);
    wr(6'h01, 4'h8, 32'h4000_0000);
    rd(6'h01, 32'hffff_0000, 32'h1090_0000);
    wr(6'h01, 4'h8, 32'h1000_0000);
    rd(6'h01, 32'hffff_0000, 32'h0090_0000);
    pulse(3'b010, 1'b1, 1'b0);
    // Flag must be set so the reset below has something to clear
    rd(6'h01, 32'hffff_0000, 32'h2090_0000);
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    rd(6'h01, 32'hffff_0000, 32'h0090_0000);
    finish_test;
  end
  // Tests take about 90 cycles; over twenty times that means a hang
  initial begin
    #20000;
    mismatches++;
    finish_test;
  end
endmodule : host_bridge_config_header_status_tb

// *** w1c_flag.sv ***
/*
  One write-one-to-clear flag. Assumes set and clear pulses on sys_clk_i.
*/
module w1c_flag (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // Events
  input  wire logic set_i,
  input  wire logic clear_i,
  // State
  output logic      flag_o
);

  typedef struct packed {
    logic flag;
  } flag_state_t;

  flag_state_t state;
  flag_state_t next_state;

  always_comb begin
    next_state = state;
    // Set beats clear so an event in the clear cycle survives
    if (clear_i) begin
      next_state.flag = 1'b0;
    end
    if (set_i) begin
      next_state.flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flag_o = state.flag;

endmodule : w1c_flag
